/* include/pmwg_consts.svh */
`ifndef PMWG_CONSTS_SVH
`define PMWG_CONSTS_SVH

// Special function register addresses
`define PMWG_ADDR_POWER_CONTROL 8'h87
`define PMWG_ADDR_EXT_IRQ_FLAGS 8'h91
`define PMWG_ADDR_TIMED_KEY 8'hC7
`define PMWG_ADDR_WDOG_CONTROL 8'hD8

// Power control fields
`define PMWG_PWR_IDLE_BIT 0
`define PMWG_PWR_STOP_BIT 1

// Extended interrupt flag fields
`define PMWG_EXTENDED_INTERRUPT_FLAGS_REF_KEEP_BIT 0
`define PMWG_EXTENDED_INTERRUPT_FLAGS_RING_SEL_BIT 1
`define PMWG_EXTENDED_INTERRUPT_FLAGS_RING_ACT_BIT 2

// Watchdog control fields; all but the power-fail flag are protected
`define PMWG_WDC_RESTART_BIT 0
`define PMWG_WDC_ENABLE_BIT 1
`define PMWG_WDC_WATCHDOG_INTERRUPT_FLAG_BIT 3
`define PMWG_WDC_PF_FLAG_BIT 4
`define PMWG_WDC_POR_BIT 6
`define PMWG_WDC_PROT_MASK 8'h4B
`define PMWG_WDC_RESET 8'h40

// Timed access keys and window length in cycles
`define PMWG_KEY_FIRST 8'hAA
`define PMWG_KEY_SECOND 8'h55
`define PMWG_KEY_WINDOW 2'h2

// Crystal clocks before leaving the ring oscillator
`define PMWG_RING_SWITCH_CLOCKS 65536

// Sources that can wake from stop: external 0 to 5
`define PMWG_STOP_WAKE_MASK 13'h0F0A
`define PMWG_NUM_SOURCES 13

// Vectors in natural priority order
`define PMWG_VEC_PFI 8'h33
`define PMWG_VEC_EXT0 8'h03
`define PMWG_VEC_TMR0 8'h0B
`define PMWG_VEC_EXT1 8'h13
`define PMWG_VEC_TMR1 8'h1B
`define PMWG_VEC_SER0 8'h23
`define PMWG_VEC_TMR2 8'h2B
`define PMWG_VEC_SER1 8'h3B
`define PMWG_VEC_EXT2 8'h43
`define PMWG_VEC_EXT3 8'h4B
`define PMWG_VEC_EXT4 8'h53
`define PMWG_VEC_EXT5 8'h5B
`define PMWG_VEC_WDOG 8'h63

`endif

/* include/pmwg_irq_if.sv */
`timescale 1ns/1ps
interface pmwg_irq_if;
  logic [12:0] req;
  logic valid;
  logic [7:0] vector;
  modport sel (input req, output valid, output vector);
  modport user (output req, input valid, input vector);
endinterface

/* include/pmwg_pkg.sv */
package pmwg_pkg;
  typedef enum logic [1:0] {
    PMWG_RUN = 2'b00,
    PMWG_IDLE = 2'b01,
    PMWG_STOP = 2'b10
  } pmwg_mode_t;

  typedef enum logic [1:0] {
    PMWG_KEY_WAIT = 2'b00,
    PMWG_KEY_HALF = 2'b01,
    PMWG_KEY_OPEN = 2'b10
  } pmwg_key_t;
endpackage

/* logic/pmwg_irq_select.sv */
`timescale 1ns/1ps
`include "pmwg_consts.svh"
module pmwg_irq_select (
  pmwg_irq_if.sel irq
);
  import pmwg_pkg::*;

  // Index 0 is the highest natural priority
  function automatic logic [7:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0: vec_of = `PMWG_VEC_PFI;
      4'h1: vec_of = `PMWG_VEC_EXT0;
      4'h2: vec_of = `PMWG_VEC_TMR0;
      4'h3: vec_of = `PMWG_VEC_EXT1;
      4'h4: vec_of = `PMWG_VEC_TMR1;
      4'h5: vec_of = `PMWG_VEC_SER0;
      4'h6: vec_of = `PMWG_VEC_TMR2;
      4'h7: vec_of = `PMWG_VEC_SER1;
      4'h8: vec_of = `PMWG_VEC_EXT2;
      4'h9: vec_of = `PMWG_VEC_EXT3;
      4'hA: vec_of = `PMWG_VEC_EXT4;
      4'hB: vec_of = `PMWG_VEC_EXT5;
      default: vec_of = `PMWG_VEC_WDOG;
    endcase
  endfunction

  // Scan from lowest priority up so the best one wins last
  always_comb begin
    irq.valid = 1'b0;
    irq.vector = 8'h00;
    for (int i = `PMWG_NUM_SOURCES - 1; i >= 0; i--) begin
      if (irq.req[i]) begin
        irq.valid = 1'b1;
        irq.vector = vec_of(4'(i));
      end
    end
  end
endmodule // pmwg_irq_select

/* logic/pmwg_power_guard.sv */
// Notes on behaviour
// - Setting the idle bit of power control enters idle.
// - Idle keeps clocks, timers and serial ports running; memory stops.
// - Any enabled interrupt or a reset ends idle.
// - Setting the stop bit gates all clocks and halts the crystal.
// - Only external interrupts, reset, or power-fail with reference kept end stop.
// - Reference is off in stop unless the keep bit is set; resets clear.
// - With reference kept, power-fail interrupt and reset wake from stop.
// - Keep bit does not affect the reference outside stop.
// - Ring select makes an interrupt wake run on the ring oscillator.
// - Ring hands over to crystal after 65536 crystal clocks.
// - Stop before the handover turns every clock off again.
// - Ring active flag reads one while the ring clocks the core.
// - Protected writes are ignored unless right after the full key.
// - Keep bit, power-on flag and watchdog bits are protected.
// - Vectors and natural priority follow the fixed thirteen-entry table.
// - Each serial port requests on transmit-done or receive-done.
`timescale 1ns/1ps
`include "pmwg_consts.svh"
module pmwg_power_guard #(
  parameter int RING_SWITCH_CLOCKS = `PMWG_RING_SWITCH_CLOCKS
) (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  input wire logic [5:0] I_EXT_IRQ,
  input wire logic [2:0] I_TIMER_OVF,
  input wire logic I_SER0_TX_DONE,
  input wire logic I_SER0_RX_DONE,
  input wire logic I_SER1_TX_DONE,
  input wire logic I_SER1_RX_DONE,
  input wire logic I_PF_IRQ,
  input wire logic I_PF_RESET,
  input wire logic I_WDOG_TIMEOUT_IRQ,
  input wire logic [12:0] I_IRQ_ENABLE,
  output logic O_CORE_CLK_EN,
  output logic O_PERIPH_CLK_EN,
  output logic O_MEM_EN,
  output logic O_XTAL_EN,
  output logic O_RING_EN,
  output logic O_REF_EN,
  output logic O_IRQ_VALID,
  output logic [7:0] O_IRQ_VECTOR,
  output logic O_WDOG_ENABLE,
  output logic O_WDOG_RESTART,
  output logic O_WAKE
);
  import pmwg_pkg::*;

  localparam int CW = $clog2(RING_SWITCH_CLOCKS + 1);
  localparam logic [CW-1:0] RING_LAST = CW'(RING_SWITCH_CLOCKS - 1);

  logic rst_meta;
  logic rst_n;
  pmwg_mode_t mode;
  pmwg_mode_t next_mode;
  pmwg_key_t key;
  pmwg_key_t next_key;
  logic [1:0] win;
  logic [1:0] next_win;
  logic ring_active;
  logic next_ring_active;
  logic [CW-1:0] ring_cnt;
  logic [CW-1:0] next_ring_cnt;
  logic [7:2] pwr_upper;
  logic [7:2] next_pwr_upper;
  logic ref_keep;
  logic next_ref_keep;
  logic ring_sel;
  logic next_ring_sel;
  logic [7:0] wdc;
  logic [7:0] next_wdc;
  logic [7:0] next_rdata;
  logic next_wake;
  logic next_restart;
  logic wr_pwr;
  logic wr_extended_interrupt_flags;
  logic wr_key;
  logic wr_wdc;
  logic ta_open;
  logic stop_wake;
  logic pf_wake;
  pmwg_irq_if irq ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Request vector in natural priority order, masked by core enables
  assign irq.req = I_IRQ_ENABLE & {I_WDOG_TIMEOUT_IRQ, I_EXT_IRQ[5:2],
    I_SER1_TX_DONE | I_SER1_RX_DONE, I_TIMER_OVF[2],
    I_SER0_TX_DONE | I_SER0_RX_DONE, I_TIMER_OVF[1],
    I_EXT_IRQ[1], I_TIMER_OVF[0], I_EXT_IRQ[0], I_PF_IRQ};

  pmwg_irq_select u_select (
    .irq(irq.sel)
  );

  // Address decode of the core's special function register writes
  always_comb begin
    wr_pwr = 1'b0;
    wr_extended_interrupt_flags = 1'b0;
    wr_key = 1'b0;
    wr_wdc = 1'b0;
    if (I_SFR_WR && I_SFR_ADDR == `PMWG_ADDR_POWER_CONTROL) begin
      wr_pwr = 1'b1;
    end else if (I_SFR_WR && I_SFR_ADDR == `PMWG_ADDR_EXT_IRQ_FLAGS) begin
      wr_extended_interrupt_flags = 1'b1;
    end else if (I_SFR_WR && I_SFR_ADDR == `PMWG_ADDR_TIMED_KEY) begin
      wr_key = 1'b1;
    end else if (I_SFR_WR && I_SFR_ADDR == `PMWG_ADDR_WDOG_CONTROL) begin
      wr_wdc = 1'b1;
    end
  end

  assign ta_open = (key == PMWG_KEY_OPEN);
  // Without clocks only external pins can wake; POWER_FAIL_INTERRUPT too if reference kept
  assign stop_wake = |(irq.req & `PMWG_STOP_WAKE_MASK)
    || (ref_keep && I_PF_IRQ);
  assign pf_wake = ref_keep && I_PF_RESET;

  // Timed access key sequence and its short window
  always_comb begin
    next_key = key;
    next_win = win;
    case (key)
      PMWG_KEY_WAIT: begin
        if (wr_key && I_SFR_WDATA == `PMWG_KEY_FIRST) begin
          next_key = PMWG_KEY_HALF;
        end
      end
      PMWG_KEY_HALF: begin
        if (wr_key && I_SFR_WDATA == `PMWG_KEY_SECOND) begin
          next_key = PMWG_KEY_OPEN;
          next_win = `PMWG_KEY_WINDOW;
        end else if (wr_key && I_SFR_WDATA == `PMWG_KEY_FIRST) begin
          next_key = PMWG_KEY_HALF;
        end else if (I_SFR_WR) begin
          next_key = PMWG_KEY_WAIT;
        end
      end
      PMWG_KEY_OPEN: begin
        next_win = win - 2'h1;
        if (wr_extended_interrupt_flags || wr_wdc || win == 2'h1) begin
          next_key = PMWG_KEY_WAIT;
        end else if (wr_key && I_SFR_WDATA == `PMWG_KEY_FIRST) begin
          next_key = PMWG_KEY_HALF;
        end else if (wr_key) begin
          next_key = PMWG_KEY_WAIT;
        end
      end
      default: begin
        next_key = PMWG_KEY_WAIT;
      end
    endcase
  end

  // Register contents; hardware sets beat software clears
  always_comb begin
    next_pwr_upper = pwr_upper;
    next_ref_keep = ref_keep;
    next_ring_sel = ring_sel;
    next_wdc = wdc;
    next_restart = 1'b0;
    if (wr_pwr) begin
      next_pwr_upper = I_SFR_WDATA[7:2];
    end
    if (wr_extended_interrupt_flags) begin
      next_ring_sel = I_SFR_WDATA[`PMWG_EXTENDED_INTERRUPT_FLAGS_RING_SEL_BIT];
      if (ta_open) begin
        next_ref_keep = I_SFR_WDATA[`PMWG_EXTENDED_INTERRUPT_FLAGS_REF_KEEP_BIT];
      end
    end
    if (wr_wdc) begin
      next_wdc = (wdc & `PMWG_WDC_PROT_MASK)
        | (I_SFR_WDATA & ~`PMWG_WDC_PROT_MASK);
      if (ta_open) begin
        next_wdc = I_SFR_WDATA;
        next_restart = I_SFR_WDATA[`PMWG_WDC_RESTART_BIT];
      end
    end
    // Restart bit is a strobe and never reads back as one
    next_wdc[`PMWG_WDC_RESTART_BIT] = 1'b0;
    if (I_WDOG_TIMEOUT_IRQ) begin
      next_wdc[`PMWG_WDC_WATCHDOG_INTERRUPT_FLAG_BIT] = 1'b1;
    end
    if (I_PF_IRQ) begin
      next_wdc[`PMWG_WDC_PF_FLAG_BIT] = 1'b1;
    end
  end

  // Power mode sequencing and the ring oscillator handover
  always_comb begin
    next_mode = mode;
    next_ring_active = ring_active;
    next_ring_cnt = ring_cnt;
    next_wake = 1'b0;
    if (ring_active && mode != PMWG_STOP) begin
      next_ring_cnt = ring_cnt + 1'b1;
      if (ring_cnt == RING_LAST) begin
        next_ring_active = 1'b0;
        next_ring_cnt = '0;
      end
    end
    case (mode)
      PMWG_RUN: begin
        if (wr_pwr && I_SFR_WDATA[`PMWG_PWR_STOP_BIT]) begin
          next_mode = PMWG_STOP;
          next_ring_active = 1'b0;
          next_ring_cnt = '0;
        end else if (wr_pwr && I_SFR_WDATA[`PMWG_PWR_IDLE_BIT]) begin
          next_mode = PMWG_IDLE;
        end
      end
      PMWG_IDLE: begin
        if (irq.valid) begin
          next_mode = PMWG_RUN;
          next_wake = 1'b1;
        end
      end
      PMWG_STOP: begin
        if (stop_wake || pf_wake) begin
          next_mode = PMWG_RUN;
          next_wake = 1'b1;
          next_ring_active = ring_sel && stop_wake;
        end
      end
      default: begin
        next_mode = PMWG_RUN;
      end
    endcase
  end

  // Registered read data; unmapped addresses read zero
  always_comb begin
    next_rdata = O_SFR_RDATA;
    if (I_SFR_RD) begin
      if (I_SFR_ADDR == `PMWG_ADDR_POWER_CONTROL) begin
        next_rdata = {pwr_upper, mode == PMWG_STOP, mode == PMWG_IDLE};
      end else if (I_SFR_ADDR == `PMWG_ADDR_EXT_IRQ_FLAGS) begin
        next_rdata = {I_EXT_IRQ[5:2], 1'b0, ring_active,
          ring_sel, ref_keep};
      end else if (I_SFR_ADDR == `PMWG_ADDR_WDOG_CONTROL) begin
        next_rdata = wdc;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // All state and every output register
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PMWG_RUN;
      key <= PMWG_KEY_WAIT;
      win <= 2'h0;
      ring_active <= 1'b0;
      ring_cnt <= '0;
      pwr_upper <= 6'h00;
      ref_keep <= 1'b0;
      ring_sel <= 1'b0;
      wdc <= `PMWG_WDC_RESET;
      O_SFR_RDATA <= 8'h00;
      O_CORE_CLK_EN <= 1'b1;
      O_PERIPH_CLK_EN <= 1'b1;
      O_MEM_EN <= 1'b1;
      O_XTAL_EN <= 1'b1;
      O_RING_EN <= 1'b0;
      O_REF_EN <= 1'b1;
      O_IRQ_VALID <= 1'b0;
      O_IRQ_VECTOR <= 8'h00;
      O_WDOG_ENABLE <= 1'b0;
      O_WDOG_RESTART <= 1'b0;
      O_WAKE <= 1'b0;
    end else begin
      mode <= next_mode;
      key <= next_key;
      win <= next_win;
      ring_active <= next_ring_active;
      ring_cnt <= next_ring_cnt;
      pwr_upper <= next_pwr_upper;
      ref_keep <= next_ref_keep;
      ring_sel <= next_ring_sel;
      wdc <= next_wdc;
      O_SFR_RDATA <= next_rdata;
      O_CORE_CLK_EN <= next_mode != PMWG_STOP;
      O_PERIPH_CLK_EN <= next_mode != PMWG_STOP;
      O_MEM_EN <= next_mode == PMWG_RUN;
      O_XTAL_EN <= next_mode != PMWG_STOP;
      O_RING_EN <= next_ring_active;
      O_REF_EN <= next_mode != PMWG_STOP || next_ref_keep;
      O_IRQ_VALID <= irq.valid;
      O_IRQ_VECTOR <= irq.vector;
      O_WDOG_ENABLE <= next_wdc[`PMWG_WDC_ENABLE_BIT];
      O_WDOG_RESTART <= next_restart;
      O_WAKE <= next_wake;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!rst_n);

  idle_entry_a: assert property (
    mode == PMWG_RUN && wr_pwr && I_SFR_WDATA[1:0] == 2'b01
    |=> mode == PMWG_IDLE ##0 !O_MEM_EN)
    else $error("idle not entered");
  idle_clocks_a: assert property (
    mode == PMWG_IDLE |-> O_PERIPH_CLK_EN && O_CORE_CLK_EN && !O_MEM_EN)
    else $error("idle clock or memory state wrong");
  idle_wake_a: assert property (
    mode == PMWG_IDLE && irq.valid |=> mode == PMWG_RUN && O_WAKE)
    else $error("idle did not end on interrupt");
  stop_clocks_a: assert property (
    mode == PMWG_STOP |-> !O_CORE_CLK_EN && !O_XTAL_EN && !O_RING_EN)
    else $error("clocks running in stop");
  stop_hold_a: assert property (
    mode == PMWG_STOP && !stop_wake && !pf_wake |=> mode == PMWG_STOP)
    else $error("stop left without a wake source");
  ref_stop_a: assert property (
    mode == PMWG_STOP |-> O_REF_EN == ref_keep)
    else $error("reference state wrong in stop");
  pf_wake_a: assert property (
    mode == PMWG_STOP && ref_keep && I_PF_RESET |=> mode == PMWG_RUN)
    else $error("power-fail did not wake stop");
  ref_run_a: assert property (
    mode != PMWG_STOP |-> O_REF_EN)
    else $error("reference off outside stop");
  ring_wake_a: assert property (
    mode == PMWG_STOP && ring_sel && stop_wake |=> ring_active && O_RING_EN)
    else $error("ring not used on wake");
  ring_switch_a: assert property (
    ring_active && ring_cnt == RING_LAST && mode != PMWG_STOP && !wr_pwr
    |=> !ring_active)
    else $error("ring handover count wrong");
  ring_restop_a: assert property (
    ring_active && mode == PMWG_RUN && wr_pwr && I_SFR_WDATA[1]
    |=> mode == PMWG_STOP && !O_RING_EN)
    else $error("stop on ring left clocks on");
  ring_flag_a: assert property (
    I_SFR_RD && I_SFR_ADDR == `PMWG_ADDR_EXT_IRQ_FLAGS
    |=> O_SFR_RDATA[2] == $past(ring_active))
    else $error("ring flag reads wrong");
  guard_block_a: assert property (
    wr_extended_interrupt_flags && !ta_open |=> ref_keep == $past(ref_keep))
    else $error("protected bit written without key");
  window_close_a: assert property (
    $rose(ta_open) |=> ##1 !ta_open)
    else $error("key window longer than two cycles");
endmodule // pmwg_power_guard

/* testbench/pmwg_core_model.sv */
`timescale 1ns/1ps
// Processor core issuing register reads and writes at clock edges
module pmwg_core_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // Bus quiet at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // Strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
  endtask

  // Released bus shows changing junk, never the last value
  task automatic idle();
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
    @(posedge i_clock);
  endtask

  // Data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1 d = i_rdata;
    @(posedge i_clock);
  endtask

  // Both key bytes, then the guarded write on the very next cycle
  task automatic keyed(input logic [7:0] a, input logic [7:0] d);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    wr(a, d);
  endtask
endmodule // pmwg_core_model

/* testbench/power_mode_and_write_guard_test.sv */
`timescale 1ns/1ps
module power_mode_and_write_guard_test;
  localparam int RING = 16;
  localparam logic [7:0] VT [13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B,
    8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  localparam logic [14:0] CR [3] = '{15'h7FFF, 15'h0001, 15'h0020};
  localparam logic [12:0] CE [3] = '{13'h1FFF, 13'h1000, 13'h0080};
  localparam logic [7:0] RA [5] = '{8'h87, 8'h91, 8'hC7, 8'hD8, 8'h55};
  localparam logic [7:0] RE [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] ext = 6'h00;
  logic [2:0] tmr = 3'h0;
  logic [3:0] ser = 4'h0; // Port 0 tx, rx, port 1 tx, rx
  logic power_fail_interrupt = 1'b0;
  logic pfr = 1'b0;
  logic wdi = 1'b0;
  logic [12:0] en = 13'h0000;
  logic wr, rd, core_en, per_en, mem_en, xtal_en, ring_en, ref_en;
  logic irq_v, wde, wdr, wake;
  logic [7:0] addr, wdata, rdata, vec, d;
  logic [8:0] e;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 77513;
  int c, n;

  pmwg_power_guard #(.RING_SWITCH_CLOCKS(RING)) dut (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .I_SFR_WR(wr), .I_SFR_RD(rd),
    .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata),
    .I_EXT_IRQ(ext), .I_TIMER_OVF(tmr), .I_SER0_TX_DONE(ser[0]),
    .I_SER0_RX_DONE(ser[1]), .I_SER1_TX_DONE(ser[2]),
    .I_SER1_RX_DONE(ser[3]), .I_PF_IRQ(power_fail_interrupt), .I_PF_RESET(pfr),
    .I_WDOG_TIMEOUT_IRQ(wdi), .I_IRQ_ENABLE(en),
    .O_CORE_CLK_EN(core_en), .O_PERIPH_CLK_EN(per_en), .O_MEM_EN(mem_en),
    .O_XTAL_EN(xtal_en), .O_RING_EN(ring_en), .O_REF_EN(ref_en),
    .O_IRQ_VALID(irq_v), .O_IRQ_VECTOR(vec), .O_WDOG_ENABLE(wde),
    .O_WDOG_RESTART(wdr), .O_WAKE(wake));

  pmwg_core_model core (
    .i_clock(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));

  // 40 MHz crystal clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset release passes two flops, so allow three edges
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Registered outputs change on the write's own edge; allow two more edges
  task automatic settle();
    core.idle();
    @(posedge clk);
    #1;
  endtask

  // Returns cyc when no wake pulse was seen
  task automatic twait(input int cyc, output int k);
    for (k = 0; k < cyc; k++) begin
      @(posedge clk);
      #1;
      if (wake === 1'b1) break;
    end
  endtask

  // Highest natural priority among enabled requests, with valid on top
  function automatic logic [8:0] expect_irq(input logic [12:0] m);
    logic [12:0] r;
    r = {wdi, ext[5:2], ser[3] | ser[2], tmr[2], ser[1] | ser[0], tmr[1],
      ext[1], tmr[0], ext[0], power_fail_interrupt} & m;
    expect_irq = 9'h000;
    for (int i = 12; i >= 0; i--)
      if (r[i]) expect_irq = {1'b1, VT[i]};
  endfunction

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #75000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    do_reset();
    check({2'h0, core_en, per_en, mem_en, xtal_en, ring_en, ref_en},
      8'h3D);
    for (int i = 0; i < 5; i++) begin
      core.rd(RA[i], d);
      check(d, RE[i]);
    end
    $display("test reset_values done");
    // Corner cases first, then sparse random request sets
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      {ext, tmr, ser, power_fail_interrupt, wdi} <= k < 3 ? CR[k] :
        15'($random(seed) & $random(seed));
      en <= k < 3 ? CE[k] : 13'($random(seed));
      repeat (2) @(posedge clk);
      #1;
      e = expect_irq(en);
      check({7'h00, irq_v}, {7'h00, e[8]});
      if (e[8]) check(vec, e[7:0]);
    end
    {ext, tmr, ser, power_fail_interrupt, wdi} <= 15'h0000;
    en <= 13'h0000;
    $display("test vectors done");
    core.wr(8'h87, 8'h01);
    settle();
    check({4'h0, core_en, per_en, mem_en, ref_en}, 8'h0D);
    wdi <= 1'b1;
    en <= 13'h1000;
    twait(10, c);
    check(8'(c < 10), 8'h01);
    check({7'h00, mem_en}, 8'h01);
    wdi <= 1'b0;
    core.keyed(8'hD8, 8'h01);
    n = 0;
    repeat (3) begin
      #1 n += int'(wdr === 1'b1);
      core.idle();
    end
    check(8'(n), 8'h01);
    $display("test idle done");
    core.wr(8'h87, 8'h02);
    settle();
    check({3'h0, core_en, per_en, mem_en, xtal_en, ref_en}, 8'h00);
    {tmr, ser, power_fail_interrupt, wdi} <= 9'h1FF;
    en <= 13'h1FF5;
    pfr <= 1'b1; // Ignored while the reference is off in stop
    twait(20, c);
    check(8'(c), 8'h14);
    ext <= 6'h08;
    twait(10, c);
    check(8'(c < 10), 8'h01);
    check({6'h00, xtal_en, ring_en}, 8'h02);
    {ext, tmr, ser, power_fail_interrupt, wdi} <= 15'h0000;
    en <= 13'h0000;
    pfr <= 1'b0;
    $display("test stop_plain done");
    core.wr(8'h91, 8'h01);
    core.idle();
    core.rd(8'h91, d);
    check(d, 8'h00);
    core.wr(8'hC7, 8'hAA);
    core.wr(8'hC7, 8'h33);
    core.wr(8'hC7, 8'h55);
    core.wr(8'h91, 8'h01);
    core.idle();
    core.rd(8'h91, d);
    check(d, 8'h00);
    core.keyed(8'h91, 8'h03);
    core.wr(8'hD8, 8'h02);
    core.idle();
    core.rd(8'h91, d);
    check(d, 8'h03);
    check({7'h00, wde}, 8'h00);
    core.keyed(8'hD8, 8'h42);
    core.wr(8'hD8, 8'h00);
    core.idle();
    core.rd(8'hD8, d);
    check(d & 8'h43, 8'h42);
    check({7'h00, wde}, 8'h01);
    $display("test key_guard done");
    core.wr(8'h87, 8'h02);
    settle();
    check({7'h00, ref_en}, 8'h01);
    ext <= 6'h01;
    en <= 13'h0002;
    twait(10, c);
    check({7'h00, ring_en}, 8'h01);
    ext <= 6'h00;
    // Back to stop before the handover; the ring must go off too
    core.wr(8'h87, 8'h02);
    settle();
    check({6'h00, core_en, ring_en}, 8'h00);
    ext <= 6'h01;
    twait(10, c);
    ext <= 6'h00;
    // No serial or timed traffic while on the ring clock
    core.rd(8'h91, d);
    check(d, 8'h07);
    for (n = 2; n < 40 && ring_en === 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check(8'(n), 8'(RING));
    core.wr(8'h87, 8'h02);
    settle();
    power_fail_interrupt <= 1'b1;
    en <= 13'h0001;
    twait(10, c);
    check(8'(c < 10), 8'h01);
    power_fail_interrupt <= 1'b0;
    en <= 13'h0000;
    // Power-fail reset wakes a kept-reference stop, on the crystal
    core.wr(8'h87, 8'h02);
    settle();
    pfr <= 1'b1;
    twait(10, c);
    pfr <= 1'b0;
    check(8'(c < 10), 8'h01);
    check({6'h00, xtal_en, ring_en}, 8'h02);
    repeat (40) @(posedge clk);
    $display("test stop_ring done");
    do_reset();
    core.rd(8'h91, d);
    check(d, 8'h00);
    core.rd(8'hD8, d);
    check(d, 8'h40);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule // power_mode_and_write_guard_test
